// *** bench/relay_model.sv ***
// Behavioural relay coils hanging on the relay driver pins
`timescale 1ns/100ps
module relay_model (
   input wire logic [relay_pkg::N_OUT-1:0] relay_drv,
   output logic [relay_pkg::N_OUT-1:0] energised
);
   // Coil pulls in while its driver pin is high; no contact bounce modelled
   assign energised = relay_drv;
endmodule

// *** bench/relay_voting_bench.sv ***
// Self-checking bench for the relay output voting logic
`timescale 1ns/100ps
module relay_voting_bench;
   typedef struct packed {
      logic [6:0] vote;
      logic norm;
      logic [2:0] cond;
      logic set;
   } row_type;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic [relay_pkg::N_IN-1:0][relay_pkg::N_LVL-1:0] alarm_lvl = '0;
   logic [relay_pkg::N_IN-1:0] in_fault = '0;
   logic [relay_pkg::N_IN-1:0] in_inhibit = '0;
   logic acknowledge_key = 1'b0;
   logic auth_ok = 1'b1;
   logic [relay_pkg::N_OUT-1:0] relay_drv;
   logic [relay_pkg::N_OUT-1:0] energised;
   int miscompares = 0;
   int check_count = 0;
   logic [31:0] d;
   row_type rows [7];

   always #4 mclk = ~mclk;

   relay_voting uut (
      .mclk(mclk),
      .arst_n(arst_n),
      .addr(addr),
      .wdata(wdata),
      .wr(wr),
      .rd(rd),
      .rdata(rdata),
      .alarm_lvl(alarm_lvl),
      .in_fault(in_fault),
      .in_inhibit(in_inhibit),
      .acknowledge_key(acknowledge_key),
      .auth_ok(auth_ok),
      .relay_drv(relay_drv)
   );

   relay_model coil (
      .relay_drv(relay_drv),
      .energised(energised)
   );

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask

   // Bounded wait; running out of cycles shows up as a mismatch
   task automatic wait_drv(input logic val);
      int n;
      n = 0;
      while (relay_drv[0] !== val && n < 12) begin
         @(posedge mclk);
         #1;
         n++;
      end
      check("relay_drv wait", {31'h0, relay_drv[0]}, {31'h0, val});
   endtask

   task automatic end_sim;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      end_sim();
   end

   initial begin
      // Conditions: [0] input 0 level 1, [1] input 1 fault, [2] input 2 inhibit
      rows[0] = '{7'h01, 1'b0, 3'b000, 1'b0};
      rows[1] = '{7'h01, 1'b0, 3'b001, 1'b1};
      rows[2] = '{7'h01, 1'b1, 3'b010, 1'b1};
      rows[3] = '{7'h03, 1'b0, 3'b011, 1'b0};
      rows[4] = '{7'h03, 1'b1, 3'b111, 1'b1};
      rows[5] = '{7'h02, 1'b1, 3'b110, 1'b1};
      rows[6] = '{7'h02, 1'b0, 3'b100, 1'b0};
      repeat (20) @(posedge mclk);
      check("relay_drv reset", {28'h0, relay_drv}, 32'h0);
      arst_n <= 1'b1;
      // Let the auth pin pass its synchroniser
      repeat (4) @(posedge mclk);
      rd_reg(relay_pkg::A_STAT, d);
      check("stat reset", d, 32'h0);
      wr_reg(relay_pkg::A_SEL, 32'h0);
      wr_reg(8'h10, 32'h01);
      wr_reg(8'h11, 32'h10);
      wr_reg(8'h12, 32'h20);
      foreach (rows[i]) begin
         wr_reg(relay_pkg::A_CTRL, {17'h0, rows[i].vote, 7'h0, rows[i].norm});
         wr_reg(relay_pkg::A_CMD, 32'h1);
         @(posedge mclk);
         alarm_lvl[0][0] <= rows[i].cond[0];
         in_fault[1] <= rows[i].cond[1];
         in_inhibit[2] <= rows[i].cond[2];
         // Active but not enabled: must never count
         alarm_lvl[3][1] <= 1'b1;
         repeat (2) @(posedge mclk);
         #1;
         check("relay_drv", {31'h0, relay_drv[0]},
               {31'h0, rows[i].set ^ rows[i].norm});
         check("coil", {31'h0, energised[0]},
               {31'h0, rows[i].set ^ rows[i].norm});
         rd_reg(relay_pkg::A_STAT, d);
         check("stat set", {31'h0, d[4]}, {31'h0, rows[i].set});
      end
      @(posedge mclk);
      alarm_lvl <= '0;
      in_fault <= '0;
      in_inhibit <= '0;
      wr_reg(relay_pkg::A_CTRL, 32'h0);
      wr_reg(relay_pkg::A_CMD, 32'h1);
      rd_reg(relay_pkg::A_STAT, d);
      check("vote invalid", {31'h0, d[2]}, 32'h1);
      wr_reg(relay_pkg::A_CMD, 32'h2);
      rd_reg(relay_pkg::A_CTRL, d);
      check("ctrl after cancel", d, 32'h200);
      @(posedge mclk);
      auth_ok <= 1'b0;
      repeat (4) @(posedge mclk);
      wr_reg(relay_pkg::A_SEL, 32'h1);
      rd_reg(relay_pkg::A_STAT, d);
      check("auth fail", {31'h0, d[3]}, 32'h1);
      rd_reg(relay_pkg::A_SEL, d);
      check("sel refused", d, 32'h100);
      @(posedge mclk);
      auth_ok <= 1'b1;
      repeat (4) @(posedge mclk);
      // Heavy-link matrix goes on a low output number
      wr_reg(relay_pkg::A_SEL, 32'h1);
      rd_reg(relay_pkg::A_SEL, d);
      check("sel new", d, 32'h1);
      rd_reg(8'h11, d);
      check("copied matrix", d, 32'h10);
      // Every condition enabled: 96 links
      for (int i = 0; i < 16; i++)
         wr_reg({relay_pkg::A_MAT_HI, i[3:0]}, 32'h3f);
      wr_reg(relay_pkg::A_CTRL, 32'h100);
      wr_reg(relay_pkg::A_CMD, 32'h1);
      rd_reg(relay_pkg::A_STAT, d);
      check("link 96", {29'h0, d[9], d[1:0]}, 32'h3);
      for (int i = 12; i < 16; i++)
         wr_reg({relay_pkg::A_MAT_HI, i[3:0]}, 32'h0);
      wr_reg(8'h1b, 32'h1f);
      wr_reg(relay_pkg::A_CMD, 32'h1);
      rd_reg(relay_pkg::A_STAT, d);
      check("link 71", {29'h0, d[9], d[1:0]}, 32'h3);
      wr_reg(8'h1b, 32'h0f);
      rd_reg(relay_pkg::A_MCNT, d);
      check("link count", d, 32'h46);
      wr_reg(relay_pkg::A_CMD, 32'h1);
      rd_reg(relay_pkg::A_STAT, d);
      check("link 70", {29'h0, d[9], d[1:0]}, 32'h5);
      rd_reg(relay_pkg::A_LOG, d);
      check("logbook", d, 32'h46);
      wr_reg(8'h10, 32'h0);
      wr_reg(relay_pkg::A_CMD, 32'h2);
      rd_reg(8'h10, d);
      check("matrix cancel", d, 32'h3f);
      wr_reg(relay_pkg::A_CMD, 32'h4);
      rd_reg(relay_pkg::A_STAT, d);
      check("cleared", {31'h0, d[9]}, 32'h0);
      rd_reg(relay_pkg::A_CTRL, d);
      check("ctrl default", d, 32'h100);
      // Output 0 again, with the new-alarm option on
      wr_reg(relay_pkg::A_SEL, 32'h0);
      wr_reg(relay_pkg::A_CTRL, 32'h102);
      wr_reg(relay_pkg::A_CMD, 32'h1);
      @(posedge mclk);
      alarm_lvl[0][0] <= 1'b1;
      wait_drv(1'b1);
      @(posedge mclk);
      acknowledge_key <= 1'b1;
      wait_drv(1'b0);
      repeat (4) @(posedge mclk);
      #1;
      check("held normal", {31'h0, relay_drv[0]}, 32'h0);
      @(posedge mclk);
      acknowledge_key <= 1'b0;
      alarm_lvl[0][0] <= 1'b0;
      repeat (3) @(posedge mclk);
      alarm_lvl[0][0] <= 1'b1;
      wait_drv(1'b1);
      check("idle drv", {29'h0, relay_drv[3:1]}, 32'h0);
      end_sim();
   end
endmodule

// *** hdl/pin_sync.sv ***
// Two-stage synchroniser for pin levels
`timescale 1ns/100ps
module pin_sync #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

// *** hdl/relay_pkg.sv ***
// Constants shared by the relay output voting logic
package relay_pkg;
   localparam int N_IN = 16;
   localparam int N_OUT = 4;
   localparam int N_LVL = 4;
   localparam int COND_PER_IN = 6;
   localparam int N_COND = N_IN * COND_PER_IN;
   localparam int CW = 7;
   localparam int SW = 2;
   // Condition slot positions inside one input's group
   localparam int SLOT_FAIL = 4;
   localparam int SLOT_INH = 5;
   // Link-calculation limits and count constants
   localparam logic [CW-1:0] LINK_WARN = 7'h3f;
   localparam logic [CW-1:0] LINK_MAX = 7'h46;
   localparam logic [CW-1:0] ONE_CNT = 7'h01;
   localparam logic [CW-1:0] ZERO_CNT = 7'h00;
   // Register addresses
   localparam logic [7:0] A_SEL = 8'h00;
   localparam logic [7:0] A_CTRL = 8'h01;
   localparam logic [7:0] A_CMD = 8'h02;
   localparam logic [7:0] A_STAT = 8'h03;
   localparam logic [7:0] A_LOG = 8'h04;
   localparam logic [7:0] A_MCNT = 8'h05;
   localparam logic [3:0] A_MAT_HI = 4'h1;
   // Field positions
   localparam int F_NORM = 0;
   localparam int F_NEW = 1;
   localparam int F_VOTE = 8;
   localparam int F_ACCEPT = 0;
   localparam int F_CANCEL = 1;
   localparam int F_CLEAR = 2;
   localparam int F_WARN = 0;
   localparam int F_REJ = 1;
   localparam int F_BAD = 2;
   localparam int F_AUTH = 3;
   localparam int F_SET = 4;
   localparam int F_CFGD = 8;
   localparam int F_SEL_CFGD = 8;
   // Values after reset and after clear
   localparam logic [CW-1:0] VOTE_DEF = 7'h01;
   localparam logic NORM_DEF = 1'b0;
   localparam logic NEW_DEF = 1'b0;
endpackage

// *** hdl/relay_voting.sv ***
// Relay output voting, acknowledge and configuration register file
`timescale 1ns/100ps
// Behaviour
// - Normal running ON: set drives pin low
// - Normal running OFF: set drives pin high
// - Energised mode: set de-energises relay
// - De-energised mode: set energises relay
// - Enabled alarm levels 1-4 count when active
// - Enabled failure counts when input faulted
// - Enabled inhibit counts when input inhibited
// - Set only when met count reaches threshold
// - Threshold 1 acts as OR
// - Threshold equal to enabled acts as AND
// - New-alarm acknowledge returns relay to normal
// - Link value over 63 warns, over 70 rejects
// - Accepted link value recorded in logbook
// - Accept adopts only valid voting settings
// - Cancel reloads pending from stored settings
// - Clear returns output to unconfigured defaults
// - Unused output number needs authorisation
// - New output inherits last displayed settings
module relay_voting (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic [relay_pkg::N_IN-1:0][relay_pkg::N_LVL-1:0] alarm_lvl,
   input wire logic [relay_pkg::N_IN-1:0] in_fault,
   input wire logic [relay_pkg::N_IN-1:0] in_inhibit,
   input wire logic acknowledge_key,
   input wire logic auth_ok,
   output logic [relay_pkg::N_OUT-1:0] relay_drv
);
   localparam int NO = relay_pkg::N_OUT;
   localparam int NC = relay_pkg::N_COND;
   localparam int CW = relay_pkg::CW;
   localparam int SW = relay_pkg::SW;

   // Checks below share one clock and one reset
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   function automatic logic mat_slot(input logic [7:0] a);
      return a[7:4] == relay_pkg::A_MAT_HI;
   endfunction

   // Pins from outside the clock domain
   logic [1:0] pin_q;
   logic ack_prev_reg;
   logic ack_pulse;
   pin_sync #(.W(2)) u_sync (
      .mclk(mclk),
      .arst_n(arst_n),
      .d({auth_ok, acknowledge_key}),
      .q(pin_q)
   );
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ack_prev_reg <= 1'b0;
      end else begin
         ack_prev_reg <= pin_q[0];
      end
   end
   assign ack_pulse = pin_q[0] && !ack_prev_reg;

   // Condition states shared by every output
   logic [NC-1:0] cond_state;
   always_comb begin
      for (int i = 0; i < relay_pkg::N_IN; i++) begin
         for (int k = 0; k < relay_pkg::N_LVL; k++) begin
            cond_state[i*relay_pkg::COND_PER_IN+k] = alarm_lvl[i][k];
         end
         cond_state[i*relay_pkg::COND_PER_IN+relay_pkg::SLOT_FAIL] =
            in_fault[i];
         cond_state[i*relay_pkg::COND_PER_IN+relay_pkg::SLOT_INH] =
            in_inhibit[i];
      end
   end

   // Stored and pending configuration
   logic [NO-1:0][NC-1:0] cfg_en;
   logic [NO-1:0][CW-1:0] cfg_vote;
   logic [NO-1:0] cfg_norm;
   logic [NO-1:0] cfg_new;
   logic [NO-1:0] cfgd;
   logic [NC-1:0] pend_en;
   logic [CW-1:0] pend_vote;
   logic pend_norm;
   logic pend_new;
   logic [SW-1:0] sel_reg;
   logic [CW-1:0] log_reg;
   logic warn_reg;
   logic rej_reg;
   logic bad_reg;
   logic auth_fail_reg;

   logic wr_sel, wr_ctrl, wr_cmd, wr_mat;
   logic do_accept, do_cancel, do_clear;
   logic [SW-1:0] new_sel;
   logic sel_allowed;
   logic [CW-1:0] pend_m;
   logic vote_ok;
   logic link_ok;
   assign wr_sel = wr && addr == relay_pkg::A_SEL;
   assign wr_ctrl = wr && addr == relay_pkg::A_CTRL;
   assign wr_cmd = wr && addr == relay_pkg::A_CMD;
   assign wr_mat = wr && mat_slot(addr);
   assign do_accept = wr_cmd && wdata[relay_pkg::F_ACCEPT];
   assign do_cancel = wr_cmd && wdata[relay_pkg::F_CANCEL]
      && !wdata[relay_pkg::F_ACCEPT];
   assign do_clear = wr_cmd && wdata[relay_pkg::F_CLEAR]
      && !wdata[relay_pkg::F_ACCEPT] && !wdata[relay_pkg::F_CANCEL];
   assign new_sel = wdata[SW-1:0];
   assign sel_allowed = cfgd[new_sel] || pin_q[1];

   // Pending matrix count is both m and the link-calculation value
   vote_if pend_vi ();
   assign pend_vi.en = pend_en;
   assign pend_vi.state = '0;
   vote_counter u_pend_cnt (.vi(pend_vi));
   assign pend_m = pend_vi.total;
   assign vote_ok = pend_vote != relay_pkg::ZERO_CNT
      && pend_vote <= pend_m;
   assign link_ok = pend_m <= relay_pkg::LINK_MAX;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sel_reg <= '0;
      end else if (wr_sel && sel_allowed) begin
         sel_reg <= new_sel;
      end
   end

   // Pending settings: the copy software edits before accept
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pend_en <= '0;
         pend_vote <= relay_pkg::VOTE_DEF;
         pend_norm <= relay_pkg::NORM_DEF;
         pend_new <= relay_pkg::NEW_DEF;
      end else if (wr_sel && sel_allowed && cfgd[new_sel]) begin
         // An unconfigured target keeps what is shown
         pend_en <= cfg_en[new_sel];
         pend_vote <= cfg_vote[new_sel];
         pend_norm <= cfg_norm[new_sel];
         pend_new <= cfg_new[new_sel];
      end else if (do_cancel) begin
         pend_en <= cfg_en[sel_reg];
         pend_vote <= cfg_vote[sel_reg];
         pend_norm <= cfg_norm[sel_reg];
         pend_new <= cfg_new[sel_reg];
      end else if (do_clear) begin
         pend_en <= '0;
         pend_vote <= relay_pkg::VOTE_DEF;
         pend_norm <= relay_pkg::NORM_DEF;
         pend_new <= relay_pkg::NEW_DEF;
      end else if (wr_ctrl) begin
         pend_norm <= wdata[relay_pkg::F_NORM];
         pend_new <= wdata[relay_pkg::F_NEW];
         pend_vote <= wdata[relay_pkg::F_VOTE+:CW];
      end else if (wr_mat) begin
         pend_en[addr[3:0]*relay_pkg::COND_PER_IN+:relay_pkg::COND_PER_IN]
            <= wdata[relay_pkg::COND_PER_IN-1:0];
      end
   end

   // Stored settings change only on a valid accept or a clear
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_en <= '0;
         cfg_vote <= {NO{relay_pkg::VOTE_DEF}};
         cfg_norm <= {NO{relay_pkg::NORM_DEF}};
         cfg_new <= {NO{relay_pkg::NEW_DEF}};
         cfgd <= '0;
      end else if (do_accept && vote_ok && link_ok) begin
         cfg_en[sel_reg] <= pend_en;
         cfg_vote[sel_reg] <= pend_vote;
         cfg_norm[sel_reg] <= pend_norm;
         cfg_new[sel_reg] <= pend_new;
         cfgd[sel_reg] <= 1'b1;
      end else if (do_clear) begin
         cfg_en[sel_reg] <= '0;
         cfg_vote[sel_reg] <= relay_pkg::VOTE_DEF;
         cfg_norm[sel_reg] <= relay_pkg::NORM_DEF;
         cfg_new[sel_reg] <= relay_pkg::NEW_DEF;
         cfgd[sel_reg] <= 1'b0;
      end
   end

   // Accept outcome flags hold until the next accept
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         warn_reg <= 1'b0;
         rej_reg <= 1'b0;
         bad_reg <= 1'b0;
      end else if (do_accept) begin
         warn_reg <= pend_m > relay_pkg::LINK_WARN;
         rej_reg <= !link_ok;
         bad_reg <= !vote_ok;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         log_reg <= relay_pkg::ZERO_CNT;
      end else if (do_accept && vote_ok && link_ok) begin
         log_reg <= pend_m;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         auth_fail_reg <= 1'b0;
      end else if (wr_sel) begin
         auth_fail_reg <= !sel_allowed;
      end
   end

   // Voting per relay output
   logic [NO-1:0] met_ok;
   logic [NO-1:0] ack_hit;
   logic [NO-1:0] set_now;
   logic [NO-1:0] set_reg;
   logic [NO-1:0] ack_reg;
   logic [NO-1:0][CW-1:0] cnt_met;
   logic [NO-1:0][CW-1:0] cnt_tot;

   generate
      for (genvar g = 0; g < NO; g++) begin : g_out
         vote_if vi ();
         assign vi.en = cfg_en[g];
         assign vi.state = cond_state;
         vote_counter u_cnt (.vi(vi));
         assign cnt_met[g] = vi.met;
         assign cnt_tot[g] = vi.total;
         // A zero threshold never fires, so an empty matrix stays idle
         assign met_ok[g] = cfgd[g] && cfg_vote[g] != relay_pkg::ZERO_CNT
            && cnt_met[g] >= cfg_vote[g];
         assign ack_hit[g] = ack_pulse && cfg_new[g] && met_ok[g];
         assign set_now[g] = met_ok[g] && !ack_reg[g] && !ack_hit[g];
         // Acknowledge holds until the vote drops, then re-arms
         always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
               ack_reg[g] <= 1'b0;
            end else begin
               ack_reg[g] <= met_ok[g] && (ack_reg[g] || ack_hit[g]);
            end
         end
         always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
               set_reg[g] <= 1'b0;
               relay_drv[g] <= 1'b0;
            end else begin
               set_reg[g] <= set_now[g];
               relay_drv[g] <= set_now[g] ^ cfg_norm[g];
            end
         end
      end
   endgenerate

   // Read port, data valid the cycle after the strobe
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= '0;
      end else if (rd) begin
         rdata <= '0;
         if (addr == relay_pkg::A_SEL) begin
            rdata[SW-1:0] <= sel_reg;
            rdata[relay_pkg::F_SEL_CFGD] <= cfgd[sel_reg];
         end else if (addr == relay_pkg::A_CTRL) begin
            rdata[relay_pkg::F_NORM] <= pend_norm;
            rdata[relay_pkg::F_NEW] <= pend_new;
            rdata[relay_pkg::F_VOTE+:CW] <= pend_vote;
         end else if (addr == relay_pkg::A_STAT) begin
            rdata[relay_pkg::F_WARN] <= warn_reg;
            rdata[relay_pkg::F_REJ] <= rej_reg;
            rdata[relay_pkg::F_BAD] <= bad_reg;
            rdata[relay_pkg::F_AUTH] <= auth_fail_reg;
            rdata[relay_pkg::F_SET+:NO] <= set_reg;
            rdata[relay_pkg::F_CFGD+:NO] <= cfgd;
         end else if (addr == relay_pkg::A_LOG) begin
            rdata[CW-1:0] <= log_reg;
         end else if (addr == relay_pkg::A_MCNT) begin
            rdata[CW-1:0] <= pend_m;
         end else if (mat_slot(addr)) begin
            rdata[relay_pkg::COND_PER_IN-1:0] <=
               pend_en[addr[3:0]*relay_pkg::COND_PER_IN+:
               relay_pkg::COND_PER_IN];
         end
      end
   end

   // Checks
   a_drv_low_on: assert property (
      set_now[0] && cfg_norm[0] |=> !relay_drv[0])
      else $error("driver not low while set in normal running on");
   a_drv_high_off: assert property (
      set_now[0] && !cfg_norm[0] |=> relay_drv[0])
      else $error("driver not high while set in normal running off");
   a_energ_drop: assert property (
      $rose(set_reg[0]) && $past(cfg_norm[0]) |-> !relay_drv[0])
      else $error("energised relay not dropped on set");
   a_deenerg_pull: assert property (
      $rose(set_reg[0]) && !$past(cfg_norm[0]) |-> relay_drv[0])
      else $error("de-energised relay not pulled on set");
   a_below_thresh: assert property (
      cnt_met[0] < cfg_vote[0] |=> !set_reg[0])
      else $error("output set below threshold");
   a_or_link: assert property (
      cfgd[0] && cfg_vote[0] == relay_pkg::ONE_CNT
      && cnt_met[0] != relay_pkg::ZERO_CNT && !ack_reg[0] && !ack_pulse
      |=> set_reg[0])
      else $error("or link failed to set");
   a_and_link: assert property (
      cfgd[0] && cfg_vote[0] == cnt_tot[0] && cnt_met[0] == cnt_tot[0]
      && cnt_tot[0] != relay_pkg::ZERO_CNT && !ack_reg[0] && !ack_pulse
      |=> set_reg[0])
      else $error("and link failed to set");
   a_ack_normal: assert property (
      ack_pulse && cfg_new[0] && met_ok[0] |=> !set_reg[0] ##1 !set_reg[0])
      else $error("acknowledge did not return output to normal");
   a_link_reject: assert property (
      do_accept && pend_m > relay_pkg::LINK_MAX |=> rej_reg && warn_reg
      && $stable(cfgd) && $stable(log_reg))
      else $error("over-limit link value not refused");
   a_log_record: assert property (
      do_accept && vote_ok && link_ok |=> log_reg == $past(pend_m)
      && cfgd[$past(sel_reg)])
      else $error("link value not logged on accept");
   a_bad_vote: assert property (
      do_accept && !vote_ok |=> bad_reg && $stable(cfg_vote))
      else $error("invalid voting adopted");
   a_cancel_reload: assert property (
      do_cancel |=> pend_en == $past(cfg_en[sel_reg]) && $stable(cfg_en))
      else $error("cancel did not restore stored settings");
   a_clear_unconf: assert property (
      do_clear |=> !cfgd[$past(sel_reg)]
      && pend_vote == relay_pkg::VOTE_DEF)
      else $error("clear did not unconfigure output");
   a_sel_auth: assert property (
      wr_sel && !cfgd[new_sel] && !pin_q[1] |=> $stable(sel_reg)
      && auth_fail_reg)
      else $error("unused output selected without authorisation");

   c_or_fire: cover property (cfg_vote[0] == relay_pkg::ONE_CNT
      && $rose(set_reg[0]));
   c_ack: cover property (ack_hit[0] ##1 met_ok[0]);
   c_accept_warn: cover property (do_accept ##1 warn_reg && !rej_reg);
   c_clear: cover property (do_clear);
endmodule

// *** hdl/vote_counter.sv ***
// Counts enabled and met conditions of one matrix
`timescale 1ns/100ps
module vote_counter (
   vote_if.counter vi
);
   always_comb begin
      logic [relay_pkg::CW-1:0] m_v;
      logic [relay_pkg::CW-1:0] t_v;
      m_v = relay_pkg::ZERO_CNT;
      t_v = relay_pkg::ZERO_CNT;
      for (int i = 0; i < relay_pkg::N_COND; i++) begin
         if (vi.en[i]) begin
            t_v = t_v + relay_pkg::ONE_CNT;
         end
         if (vi.en[i] && vi.state[i]) begin
            m_v = m_v + relay_pkg::ONE_CNT;
         end
      end
      vi.met = m_v;
      vi.total = t_v;
   end
endmodule

// *** hdl/vote_if.sv ***
// Condition vectors and counts between the voting core and a counter
`timescale 1ns/100ps
interface vote_if;
   logic [relay_pkg::N_COND-1:0] en;
   logic [relay_pkg::N_COND-1:0] state;
   logic [relay_pkg::CW-1:0] met;
   logic [relay_pkg::CW-1:0] total;
   modport counter (input en, input state, output met, output total);
   modport user (output en, output state, input met, input total);
endinterface
